// ### core/kbc_host_mailbox.sv
// Keyboard-controller host mailbox, port glue and power-down control
// =============================================================
`timescale 1ns/1ps
module kbc_host_mailbox (
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RST_B,
    // Host I/O port
    input  wire logic                        HOST_WR,
    input  wire logic                        HOST_RD,
    input  wire logic                        HOST_ADDR_BIT_TWO,
    input  wire logic [7:0]                  HOST_WDATA,
    output logic      [7:0]                  HOST_RDATA,
    // Interrupt and gate outputs
    output logic                             KBD_INTERRUPT_OUT,
    output logic                             AUX_INTERRUPT_OUT,
    output logic                             GATE_A20_OUT,
    // Controller side of the buffers
    input  wire logic                        UC_IN_RD,
    output logic      [7:0]                  UC_IN_DATA,
    input  wire logic                        UC_OUT_VALID,
    input  wire logic [7:0]                  UC_OUT_DATA,
    output logic                             UC_OUT_READY,
    input  wire logic                        UC_STATUS_WR,
    input  wire logic [7:0]                  UC_STATUS_WDATA,
    output logic      [7:0]                  UC_STATUS,
    input  wire logic                        UC_EN_FLAGS,
    // Controller ports
    input  wire logic                        UC_P1_WR,
    input  wire logic [7:0]                  UC_P1_WDATA,
    input  wire logic                        UC_P2_WR,
    input  wire logic [7:0]                  UC_P2_WDATA,
    output logic      [kbc_pkg::SENSE_N-1:0] UC_SENSE,
    // Pin configuration
    input  wire logic                        KBC_MODE,
    input  wire logic                        QUASI_OPEN_DRAIN,
    input  wire logic [kbc_pkg::QUASI_N-1:0] GP_INVERT_CFG,
    input  wire logic [kbc_pkg::QUASI_N-1:0] GP_INPUT_CFG,
    // Quasi-bidirectional pins
    input  wire logic [kbc_pkg::QUASI_N-1:0] QUASI_PORT_I,
    output logic      [kbc_pkg::QUASI_N-1:0] QUASI_PORT_O,
    output logic      [kbc_pkg::QUASI_N-1:0] QUASI_PORT_OE,
    // Keyboard and mouse open-drain lines (keyboard_clock_line, keyboard_data_line, mclk, mouse_data_line)
    input  wire logic [3:0]                  KM_LINE_I,
    output logic      [3:0]                  KM_LINE_O,
    output logic      [3:0]                  KM_LINE_OE,
    // Core power and interrupt control
    input  wire logic                        UC_HALT,
    input  wire logic                        UC_STOP,
    input  wire logic                        UC_IBF_INT_EN,
    input  wire logic                        UC_TMR_INT_EN,
    input  wire logic                        TMR_OVF,
    input  wire logic                        UC_TMR_ACK,
    output logic                             ALU_CLK_EN,
    output logic                             OSC_EN,
    output logic                             WAKE_CALL,
    output logic                             WAKE_NEXT,
    output logic                             CORE_RESTART,
    output logic                             CORE_IRQ_IBF,
    output logic                             CORE_IRQ_TMR,
    // Program store and data RAM
    input  wire logic                        PROG_LOAD_WE,
    input  wire logic [kbc_pkg::PROG_AW-1:0] PROG_LOAD_ADDR,
    input  wire logic [7:0]                  PROG_LOAD_DATA,
    input  wire logic [kbc_pkg::PROG_AW-1:0] PROG_ADDR,
    output logic      [7:0]                  PROG_DATA,
    input  wire logic                        RAM_WE,
    input  wire logic [kbc_pkg::RAM_AW-1:0]  RAM_ADDR,
    input  wire logic [7:0]                  RAM_WDATA,
    output logic      [7:0]                  RAM_RDATA
);
    import kbc_pkg::*;

    logic [7:0] status_r;
    logic [7:0] in_data_r;
    logic [7:0] out_data_r;
    logic [7:0] p1_r;
    logic [7:0] p2_r;
    logic       flags_r;
    logic       drain;
    logic       host_rd_data;
    logic [7:0] buf_mem [2];
    logic [1:0] buf_cnt_r;
    logic [1:0] buf_cnt_nxt;
    logic       buf_wp_r;
    logic       buf_rp_r;
    logic       buf_push;
    logic       tmr_pend_r;
    pd_state_t  pd_r;

    assign host_rd_data = HOST_RD && !HOST_ADDR_BIT_TWO;

    // =========================================================
    // Host and controller buffers
    always_ff @(posedge CLK) begin
        if (HOST_WR) begin
            in_data_r <= HOST_WDATA;
        end
        if (drain) begin
            out_data_r <= buf_mem[buf_rp_r];
        end
    end

    always_ff @(posedge CLK) begin
        if (UC_IN_RD) begin
            UC_IN_DATA <= in_data_r;
        end
        if (HOST_RD) begin
            HOST_RDATA <= HOST_ADDR_BIT_TWO ? status_r : out_data_r;
        end
    end

    // =========================================================
    // Two-entry buffer in front of the output data register
    assign buf_push = UC_OUT_VALID && UC_OUT_READY;
    assign drain    = (buf_cnt_r != 2'd0) && !status_r[ST_OBF];

    always_comb begin
        buf_cnt_nxt = buf_cnt_r;
        if (buf_push && !drain) begin
            buf_cnt_nxt = buf_cnt_r + 2'd1;
        end else if (drain && !buf_push) begin
            buf_cnt_nxt = buf_cnt_r - 2'd1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            buf_cnt_r    <= 2'd0;
            buf_wp_r     <= 1'b0;
            buf_rp_r     <= 1'b0;
            UC_OUT_READY <= 1'b0;
        end else begin
            buf_cnt_r    <= buf_cnt_nxt;
            UC_OUT_READY <= buf_cnt_nxt != 2'd2;
            if (buf_push) begin
                buf_mem[buf_wp_r] <= UC_OUT_DATA;
                buf_wp_r          <= !buf_wp_r;
            end
            if (drain) begin
                buf_rp_r <= !buf_rp_r;
            end
        end
    end

    // =========================================================
    // Status register
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            status_r <= ST_RESET;
        end else begin
            if (UC_STATUS_WR) begin
                status_r <= (status_r & ~ST_UD_MASK)
                          | (UC_STATUS_WDATA & ST_UD_MASK);
            end
            if (HOST_WR) begin
                status_r[ST_CMD] <= HOST_ADDR_BIT_TWO;
            end
            if (HOST_WR) begin
                status_r[ST_IBF] <= 1'b1;
            end else if (UC_IN_RD) begin
                status_r[ST_IBF] <= 1'b0;
            end
            if (drain) begin
                status_r[ST_OBF] <= 1'b1;
            end else if (host_rd_data) begin
                status_r[ST_OBF] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            UC_STATUS <= ST_RESET;
        end else begin
            UC_STATUS <= status_r;
        end
    end

    // =========================================================
    // Ports and flag gating
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            p1_r    <= P1_RESET;
            p2_r    <= P2_RESET;
            flags_r <= 1'b0;
        end else begin
            if (UC_P1_WR) begin
                p1_r <= UC_P1_WDATA;
            end
            if (UC_P2_WR) begin
                p2_r <= UC_P2_WDATA;
            end
            if (UC_EN_FLAGS) begin
                flags_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            KBD_INTERRUPT_OUT <= 1'b0;
            AUX_INTERRUPT_OUT <= 1'b0;
            GATE_A20_OUT      <= 1'b0;
        end else begin
            KBD_INTERRUPT_OUT <= flags_r
                ? (p2_r[P2_KBD_IRQ] && status_r[ST_OBF])
                : p2_r[P2_KBD_IRQ];
            AUX_INTERRUPT_OUT <= flags_r
                ? (p2_r[P2_AUX_IRQ] && !status_r[ST_IBF])
                : p2_r[P2_AUX_IRQ];
            GATE_A20_OUT <= p2_r[P2_GATE_A20];
        end
    end

    // =========================================================
    // Keyboard and mouse open-drain lines
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            KM_LINE_O  <= 4'h0;
            KM_LINE_OE <= 4'hf;
        end else begin
            KM_LINE_O  <= 4'h0;
            KM_LINE_OE <= {p2_r[P2_MOUSE_DATA], p2_r[P2_MOUSE_CLK],
                           p2_r[P2_KBD_DATA], p2_r[P2_KBD_CLK]};
        end
    end

    // =========================================================
    // Sense synchronisers: lines then quasi pins
    logic [SENSE_N-1:0] sense_raw;
    assign sense_raw = {QUASI_PORT_I, KM_LINE_I};

    generate
        for (genvar s = 0; s < SENSE_N; s++) begin : g_sense
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    s1_r        <= 1'b1;
                    s2_r        <= 1'b1;
                    s3_r        <= 1'b1;
                    UC_SENSE[s] <= 1'b1;
                end else begin
                    s1_r <= sense_raw[s];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        UC_SENSE[s] <= s3_r;
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // Quasi-bidirectional outputs
    localparam int QUASI_POS [QUASI_N] = '{P1_QUASI_C, P1_QUASI_B,
                                           P1_QUASI_A};

    generate
        for (genvar q = 0; q < QUASI_N; q++) begin : g_quasi
            logic              bit_q;
            logic              bit_prev_r;
            logic [HOLD_W-1:0] hold_r;
            assign bit_q = p1_r[QUASI_POS[q]]
                         ^ (!KBC_MODE && GP_INVERT_CFG[q]);
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    bit_prev_r       <= 1'b1;
                    hold_r           <= '0;
                    QUASI_PORT_O[q]  <= 1'b1;
                    QUASI_PORT_OE[q] <= 1'b0;
                end else begin
                    bit_prev_r <= bit_q;
                    if (bit_q && !bit_prev_r) begin
                        hold_r <= HOLD_W'(QUASI_HOLD_CYC);
                    end else if (!bit_q) begin
                        hold_r <= '0;
                    end else if (hold_r != '0) begin
                        hold_r <= hold_r - 1'b1;
                    end
                    QUASI_PORT_O[q] <= bit_q;
                    // input setting ignored in controller mode
                    if (!KBC_MODE && GP_INPUT_CFG[q]) begin
                        QUASI_PORT_OE[q] <= 1'b0;
                    end else if (QUASI_OPEN_DRAIN) begin
                        QUASI_PORT_OE[q] <= !bit_q;
                    end else begin
                        QUASI_PORT_OE[q] <= !bit_q
                            || (bit_q && !bit_prev_r) || (hold_r > 1);
                    end
                end
            end
            a_od_never_high: assert property (@(posedge CLK)
                disable iff (!RST_B)
                QUASI_OPEN_DRAIN |=> !(QUASI_PORT_OE[q]
                    && QUASI_PORT_O[q] && $past(QUASI_OPEN_DRAIN)))
                else $error("open-drain pin driven high");
        end
    endgenerate

    // =========================================================
    // Power-down, wake and core interrupts
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pd_r      <= PD_RUN;
            WAKE_CALL <= 1'b0;
            WAKE_NEXT <= 1'b0;
        end else begin
            WAKE_CALL <= 1'b0;
            WAKE_NEXT <= 1'b0;
            case (pd_r)
                PD_RUN: begin
                    if (UC_STOP) begin
                        pd_r <= PD_HARD;
                    end else if (UC_HALT) begin
                        pd_r <= PD_SOFT;
                    end
                end
                PD_SOFT, PD_HARD: begin
                    if (HOST_WR) begin
                        pd_r      <= PD_RUN;
                        WAKE_CALL <= UC_IBF_INT_EN;
                        WAKE_NEXT <= !UC_IBF_INT_EN;
                    end
                end
                default: pd_r <= PD_RUN;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ALU_CLK_EN   <= 1'b0;
            OSC_EN       <= 1'b1;
            CORE_RESTART <= 1'b1;
            tmr_pend_r   <= 1'b0;
            CORE_IRQ_IBF <= 1'b0;
            CORE_IRQ_TMR <= 1'b0;
        end else begin
            CORE_RESTART <= 1'b0;
            ALU_CLK_EN   <= pd_r == PD_RUN;
            OSC_EN       <= pd_r != PD_HARD;
            if (TMR_OVF) begin
                tmr_pend_r <= 1'b1;
            end else if (UC_TMR_ACK) begin
                tmr_pend_r <= 1'b0;
            end
            CORE_IRQ_IBF <= status_r[ST_IBF] && UC_IBF_INT_EN;
            CORE_IRQ_TMR <= tmr_pend_r && UC_TMR_INT_EN;
        end
    end

    // =========================================================
    // program store and data RAM
    byte_mem #(.DEPTH(PROG_DEPTH), .AW(PROG_AW)) u_prog (
        .clk   (CLK),
        .we    (PROG_LOAD_WE),
        .waddr (PROG_LOAD_ADDR),
        .wdata (PROG_LOAD_DATA),
        .raddr (PROG_ADDR),
        .rdata (PROG_DATA)
    );

    byte_mem #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
        .clk   (CLK),
        .we    (RAM_WE),
        .waddr (RAM_ADDR),
        .wdata (RAM_WDATA),
        .raddr (RAM_ADDR),
        .rdata (RAM_RDATA)
    );

    // =========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_obf_on_write: assert property (
        drain |=> status_r[ST_OBF] ##1 UC_STATUS[ST_OBF])
        else $error("output-full not set by buffer write");
    a_cmd_flag_load: assert property (
        HOST_WR |=> status_r[ST_CMD] == $past(HOST_ADDR_BIT_TWO))
        else $error("command flag not loaded from address bit");
    a_kbd_interrupt_out_gated: assert property (
        (flags_r && p2_r[P2_KBD_IRQ]) |=>
            KBD_INTERRUPT_OUT == $past(status_r[ST_OBF]))
        else $error("keyboard interrupt not following output-full");
    a_kbd_interrupt_out_direct: assert property (
        !flags_r |=> KBD_INTERRUPT_OUT == $past(p2_r[P2_KBD_IRQ]))
        else $error("keyboard interrupt not following port bit");
    a_kbd_interrupt_out_reset: assert property (
        $rose(RST_B) |-> !KBD_INTERRUPT_OUT)
        else $error("keyboard interrupt high after reset");
    a_aux_interrupt_out_gated: assert property (
        (flags_r && p2_r[P2_AUX_IRQ]) |=>
            AUX_INTERRUPT_OUT != $past(status_r[ST_IBF]))
        else $error("aux interrupt not inverse of input-full");
    a_aux_interrupt_out_direct: assert property (
        !flags_r |=> AUX_INTERRUPT_OUT == $past(p2_r[P2_AUX_IRQ]))
        else $error("aux interrupt not following port bit");
    a_line_invert: assert property (
        UC_P2_WR |=> ##1 KM_LINE_OE[0] == $past(UC_P2_WDATA[P2_KBD_CLK], 2))
        else $error("keyboard clock line not inverted port bit");
    a_ibf_cleared: assert property (
        (UC_IN_RD && !HOST_WR) |=> !status_r[ST_IBF])
        else $error("input-full not cleared by controller read");
    a_obf_cleared: assert property (
        (host_rd_data && !drain) |=> !status_r[ST_OBF])
        else $error("output-full not cleared by host read");
    a_wake_call: assert property (
        (pd_r != PD_RUN && HOST_WR) |=>
            WAKE_CALL == $past(UC_IBF_INT_EN) && WAKE_NEXT != WAKE_CALL
            ##1 ALU_CLK_EN)
        else $error("wake from power-down mis-sequenced");
    a_hard_osc_off: assert property (
        (pd_r == PD_RUN && UC_STOP) |=> ##1 !OSC_EN && !ALU_CLK_EN)
        else $error("oscillator not stopped in hard power-down");
endmodule // kbc_host_mailbox

// ### core/kbc_pkg.sv
// Constants and types shared by the keyboard-controller host mailbox
package kbc_pkg;
    // =========================================================
    // Timing
    localparam int CLK_MHZ        = 250;
    localparam int QUASI_HOLD_NS  = 500;
    localparam int QUASI_HOLD_CYC = (QUASI_HOLD_NS * CLK_MHZ) / 1000;
    localparam int HOLD_W         = 8;
    // =========================================================
    // Status register layout
    localparam int        ST_OBF      = 0;
    localparam int        ST_IBF      = 1;
    localparam int        ST_CMD      = 3;
    localparam logic [7:0] ST_RESET   = 8'h00;
    localparam logic [7:0] ST_UD_MASK = 8'hf4;
    // =========================================================
    // Port 2 bit positions
    localparam int P2_GATE_A20   = 1;
    localparam int P2_MOUSE_DATA = 2;
    localparam int P2_MOUSE_CLK  = 3;
    localparam int P2_KBD_IRQ    = 4;
    localparam int P2_AUX_IRQ    = 5;
    localparam int P2_KBD_CLK    = 6;
    localparam int P2_KBD_DATA   = 7;
    localparam logic [7:0] P2_RESET = 8'hcc;
    // =========================================================
    // Port 1 quasi-bidirectional bits (a, b, c)
    localparam int QUASI_N = 3;
    localparam int P1_QUASI_A = 7;
    localparam int P1_QUASI_B = 6;
    localparam int P1_QUASI_C = 2;
    localparam logic [7:0] P1_RESET = 8'hff;
    // =========================================================
    // Memories
    localparam int PROG_DEPTH = 2048;
    localparam int PROG_AW    = 11;
    localparam int RAM_DEPTH  = 256;
    localparam int RAM_AW     = 8;
    // =========================================================
    // Sense synchroniser width and power-down states
    localparam int SENSE_N = 7;
    typedef enum logic [1:0] {PD_RUN, PD_SOFT, PD_HARD} pd_state_t;
endpackage

// ### core/byte_mem.sv
// Byte-wide memory with registered read data
`timescale 1ns/1ps
module byte_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // Clock
    input  wire logic          clk,
    // Write side
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read side
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule // byte_mem

// ### sim/kbc_host_model.sv
// Host-side model making data and command port cycles
`timescale 1ns/1ps
module kbc_host_model (
    // Clock
    input  wire logic       CLK,
    // Host port
    output logic            HOST_WR,
    output logic            HOST_RD,
    output logic            HOST_ADDR_BIT_TWO,
    output logic [7:0]      HOST_WDATA,
    input  wire logic [7:0] HOST_RDATA
);
    initial {HOST_WR, HOST_RD, HOST_ADDR_BIT_TWO, HOST_WDATA} = '0;
    // data port or command port write
    task automatic io_wr(input logic cmd, input logic [7:0] d);
        @(posedge CLK);
        HOST_WR           <= 1'b1;
        HOST_ADDR_BIT_TWO <= cmd;
        HOST_WDATA        <= d;
        @(posedge CLK);
        HOST_WR    <= 1'b0;
        HOST_WDATA <= ~d;
    endtask
    task automatic io_rd(input logic cmd, output logic [7:0] d);
        @(posedge CLK);
        HOST_RD           <= 1'b1;
        HOST_ADDR_BIT_TWO <= cmd;
        @(posedge CLK);
        HOST_RD <= 1'b0;
        #1 d = HOST_RDATA;
    endtask
endmodule // kbc_host_model

// ### sim/kbc_host_mailbox_tb.sv
// Self-checking bench for the keyboard-controller host mailbox
`timescale 1ns/1ps
module kbc_host_mailbox_tb;
    logic       CLK, RST_B, HOST_WR, HOST_RD, HOST_ADDR_BIT_TWO, RAM_WE;
    logic       UC_IN_RD, UC_OUT_VALID, UC_OUT_READY, UC_STATUS_WR;
    logic       UC_EN_FLAGS, UC_P1_WR, UC_P2_WR, KBC_MODE, QUASI_OPEN_DRAIN;
    logic       UC_HALT, UC_STOP, UC_IBF_INT_EN, UC_TMR_INT_EN, TMR_OVF;
    logic       UC_TMR_ACK, PROG_LOAD_WE, GATE_A20_OUT;
    logic       KBD_INTERRUPT_OUT, AUX_INTERRUPT_OUT;
    logic       ALU_CLK_EN, OSC_EN, WAKE_CALL, WAKE_NEXT, CORE_IRQ_IBF;
    logic [2:0] QUASI_PORT_O, QUASI_PORT_OE;
    logic [7:0] HOST_WDATA, HOST_RDATA, UC_IN_DATA, UC_OUT_DATA, UC_STATUS;
    logic [7:0] UC_STATUS_WDATA, UC_P1_WDATA, UC_P2_WDATA, PROG_LOAD_DATA;
    logic [7:0] RAM_ADDR, RAM_WDATA;
    logic [2:0] GP_INVERT_CFG, GP_INPUT_CFG, QUASI_PORT_I;
    logic [3:0] KM_LINE_I, KM_LINE_OE;
    logic [6:0] UC_SENSE;
    logic [10:0] PROG_LOAD_ADDR, PROG_ADDR;
    int         error_cnt = 0;
    int         num_checks = 0;
    logic [7:0] d;
    // Pulled-up pins, low only where the block drives low
    assign KM_LINE_I = ~KM_LINE_OE;
    assign QUASI_PORT_I = ~QUASI_PORT_OE | QUASI_PORT_O;
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // ====
    // Instances
    kbc_host_model u_host (.CLK, .HOST_WR, .HOST_RD, .HOST_ADDR_BIT_TWO,
        .HOST_WDATA, .HOST_RDATA);
    kbc_host_mailbox u_dut (.CLK, .RST_B, .HOST_WR, .HOST_RD,
        .HOST_ADDR_BIT_TWO, .HOST_WDATA, .HOST_RDATA, .KBD_INTERRUPT_OUT,
        .AUX_INTERRUPT_OUT, .GATE_A20_OUT, .UC_IN_RD, .UC_IN_DATA,
        .UC_OUT_VALID, .UC_OUT_DATA, .UC_OUT_READY, .UC_STATUS_WR,
        .UC_STATUS_WDATA, .UC_STATUS, .UC_EN_FLAGS, .UC_P1_WR, .UC_P1_WDATA,
        .UC_P2_WR, .UC_P2_WDATA, .UC_SENSE, .KBC_MODE, .QUASI_OPEN_DRAIN,
        .GP_INVERT_CFG, .GP_INPUT_CFG, .QUASI_PORT_I, .QUASI_PORT_O,
        .QUASI_PORT_OE, .KM_LINE_I, .KM_LINE_O(), .KM_LINE_OE, .UC_HALT,
        .UC_STOP, .UC_IBF_INT_EN, .UC_TMR_INT_EN, .TMR_OVF, .UC_TMR_ACK,
        .ALU_CLK_EN, .OSC_EN, .WAKE_CALL, .WAKE_NEXT,
        .CORE_RESTART(), .CORE_IRQ_IBF, .CORE_IRQ_TMR(), .PROG_LOAD_WE,
        .PROG_LOAD_ADDR, .PROG_LOAD_DATA, .PROG_ADDR, .PROG_DATA(), .RAM_WE,
        .RAM_ADDR, .RAM_WDATA, .RAM_RDATA());
    // ====
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic p2_wr(input logic [7:0] v);
        @(posedge CLK);
        UC_P2_WR    <= 1'b1;
        UC_P2_WDATA <= v;
        @(posedge CLK);
        UC_P2_WR <= 1'b0;
    endtask
    task automatic in_rd;
        @(posedge CLK);
        UC_IN_RD <= 1'b1;
        @(posedge CLK);
        UC_IN_RD <= 1'b0;
        tick(2);
    endtask
    task automatic out_byte(input logic [7:0] v);
        @(posedge CLK);
        UC_OUT_VALID <= 1'b1;
        UC_OUT_DATA  <= v;
        @(posedge CLK);
        UC_OUT_VALID <= 1'b0;
        tick(3);
    endtask
    task automatic p1_wr(input logic [7:0] v);
        @(posedge CLK);
        UC_P1_WR    <= 1'b1;
        UC_P1_WDATA <= v;
        @(posedge CLK);
        UC_P1_WR <= 1'b0;
    endtask
    task automatic do_reset;
        @(posedge CLK);
        RST_B <= 1'b0;
        repeat (26) @(posedge CLK);
        RST_B <= 1'b1;
        tick(1);
    endtask
    // ====
    // Scenarios
    task automatic t_reset;
        chk(UC_STATUS, 8'h00);
        chk(KM_LINE_OE, 8'h0f);
        chk(KBD_INTERRUPT_OUT, 8'h00);
        chk(UC_OUT_READY, 8'h01);
        u_host.io_rd(1'b1, d);
        chk(d, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_ungated;
        logic [7:0] v;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'ha5 : 8'h5a;
            p2_wr(v);
            tick(6);
            chk(KBD_INTERRUPT_OUT, v[4]);
            chk(AUX_INTERRUPT_OUT, v[5]);
            chk(GATE_A20_OUT, v[1]);
            chk(KM_LINE_OE, {v[2], v[3], v[7], v[6]});
            chk(UC_SENSE[3:0] ^ {v[2], v[3], v[7], v[6]}, 8'h0f);
        end
        $display("ungated test done");
    endtask
    task automatic t_host_in;
        u_host.io_wr(1'b1, 8'h3c);
        tick(2);
        chk(UC_STATUS & 8'h0b, 8'h0a);
        in_rd;
        chk(UC_IN_DATA, 8'h3c);
        chk(UC_STATUS & 8'h02, 8'h00);
        u_host.io_wr(1'b0, 8'hc3);
        u_host.io_rd(1'b1, d);
        chk(d & 8'h0b, 8'h02);
        in_rd;
        $display("host input test done");
    endtask
    task automatic t_gated;
        @(posedge CLK);
        UC_EN_FLAGS <= 1'b1;
        @(posedge CLK);
        UC_EN_FLAGS <= 1'b0;
        p2_wr(8'h30);
        tick(2);
        chk(AUX_INTERRUPT_OUT, 8'h01);
        chk(KBD_INTERRUPT_OUT, 8'h00);
        out_byte(8'h96);
        chk(KBD_INTERRUPT_OUT, 8'h01);
        u_host.io_wr(1'b0, 8'h11);
        tick(2);
        chk(AUX_INTERRUPT_OUT, 8'h00);
        u_host.io_rd(1'b0, d);
        chk(d, 8'h96);
        tick(2);
        chk(KBD_INTERRUPT_OUT, 8'h00);
        chk(UC_STATUS & 8'h01, 8'h00);
        in_rd;
        chk(AUX_INTERRUPT_OUT, 8'h01);
        p2_wr(8'h20);
        out_byte(8'h44);
        chk(KBD_INTERRUPT_OUT, 8'h00);
        chk(UC_STATUS & 8'h01, 8'h01);
        $display("gated test done");
    endtask
    task automatic t_quasi;
        p1_wr(8'h00);
        tick(6);
        chk(QUASI_PORT_OE, 8'h07);
        chk(QUASI_PORT_O | UC_SENSE[6:4], 8'h00);
        p1_wr(8'hff);
        tick(2);
        chk(QUASI_PORT_OE & QUASI_PORT_O, 8'h07);
        tick(kbc_pkg::QUASI_HOLD_CYC - 15);
        chk(QUASI_PORT_OE, 8'h07);
        tick(20);
        chk(QUASI_PORT_OE, 8'h00);
        @(posedge CLK);
        QUASI_OPEN_DRAIN <= 1'b1;
        {GP_INVERT_CFG, GP_INPUT_CFG} <= 6'h3f;
        p1_wr(8'h00);
        tick(2);
        chk({QUASI_PORT_OE, QUASI_PORT_O}, 8'h38);
        p1_wr(8'hff);
        tick(6);
        chk({QUASI_PORT_OE, UC_SENSE[6:4]}, 8'h07);
        $display("quasi test done");
    endtask
    task automatic t_power;
        @(posedge CLK);
        UC_STATUS_WR    <= 1'b1;
        UC_STATUS_WDATA <= 8'hff;
        UC_HALT         <= 1'b1;
        @(posedge CLK);
        {UC_STATUS_WR, UC_HALT} <= 2'b00;
        tick(2);
        chk({ALU_CLK_EN, OSC_EN}, 8'h01);
        u_host.io_wr(1'b0, 8'h55);
        tick(0);
        chk({WAKE_CALL, WAKE_NEXT}, 8'h01);
        tick(1);
        chk(ALU_CLK_EN, 8'h01);
        u_host.io_rd(1'b1, d);
        chk(d & 8'hf4, 8'hf4);
        @(posedge CLK);
        UC_IBF_INT_EN <= 1'b1;
        UC_STOP       <= 1'b1;
        @(posedge CLK);
        UC_STOP <= 1'b0;
        tick(2);
        chk({ALU_CLK_EN, OSC_EN}, 8'h00);
        u_host.io_wr(1'b1, 8'h77);
        tick(0);
        chk({WAKE_CALL, WAKE_NEXT}, 8'h02);
        tick(1);
        chk({ALU_CLK_EN, OSC_EN, CORE_IRQ_IBF}, 8'h07);
        $display("power test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        {RST_B, UC_IN_RD, UC_OUT_VALID, UC_STATUS_WR, UC_EN_FLAGS, UC_P1_WR,
         UC_P2_WR, QUASI_OPEN_DRAIN, UC_HALT, UC_STOP, UC_IBF_INT_EN,
         UC_TMR_INT_EN, TMR_OVF, UC_TMR_ACK, PROG_LOAD_WE, RAM_WE,
         UC_OUT_DATA, UC_STATUS_WDATA, UC_P1_WDATA, UC_P2_WDATA,
         PROG_LOAD_DATA, RAM_ADDR, RAM_WDATA, GP_INVERT_CFG, GP_INPUT_CFG,
         PROG_LOAD_ADDR, PROG_ADDR} = '0;
        KBC_MODE = 1'b1;
        do_reset;
        t_reset;
        t_ungated;
        t_host_in;
        t_gated;
        t_quasi;
        t_power;
        do_reset;
        t_reset;
        tally_and_finish;
    end
endmodule // kbc_host_mailbox_tb
